// File: logic/nv_load_if.sv
`timescale 1ns/1ps
interface nv_load_if;
  logic        start;
  logic        busy;
  logic        done;
  logic [2:0]  idx;
  logic [31:0] word;
  modport ctrl (output start, input busy, done, idx, word);
  modport ldr  (input start, output busy, done, idx, word);
endinterface

// File: logic/nv_loader.sv
`timescale 1ns/1ps
module nv_loader (
  input  wire logic pclk,
  input  wire logic presetn,
  nv_load_if.ldr    ld,
  input  wire logic [31:0] nv_data,
  output logic      [2:0]  nv_addr
);
  logic [3:0] cnt_q;
  // Walks the store one word per cycle; word idx 0/1 are the plan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (ld.start) begin
      cnt_q <= pll_ctrl_pkg::load_words;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign ld.busy  = (cnt_q != 4'h0);
  assign ld.done  = (cnt_q == 4'h1);
  assign ld.idx   = 3'(pll_ctrl_pkg::load_words - cnt_q);
  assign ld.word  = nv_data;
  // One word ahead; the top registers it, so the store answers in step with idx
  assign nv_addr  = ld.start ? 3'h0 : (ld.busy ? ld.idx + 3'h1 : ld.idx);
endmodule

// File: logic/pll_ctrl_pkg.sv
// Operation
// - Power-up loads defaults from nonvolatile store first
// - Serial access blocked until initialization completes
// - Output clocks held inactive during initialization
// - Hard reset reloads everything like power-up
// - Hard reset from pin or register bit
// - Soft reset applies pending config, no reload
// - Exactly one of four loop modes after init
// - Normal bandwidth from register, 0.1 Hz-4 kHz
// - Fast-lock bandwidth used during acquisition when enabled
// - Fast-lock bandwidth accepts 100 Hz to 4 kHz
// - Revert to normal bandwidth once lock completes
// - Reference selection manual or automatic state machine
// - Frequency plan from host or nonvolatile store
// - Enter free-run automatically after initialization
// - Valid input starts acquisition from free-run/holdover
// - Holdover when selected input lost, none valid
// - Leave holdover when input valid again, reacquire
package pll_ctrl_pkg;
  localparam logic [11:0] ctrl_off      = 12'h000;
  localparam logic [11:0] bw_off        = 12'h004;
  localparam logic [11:0] refsel_off    = 12'h008;
  localparam logic [11:0] plan_m_off    = 12'h00c;
  localparam logic [11:0] plan_n_off    = 12'h010;
  localparam logic [11:0] status_off    = 12'h014;
  localparam logic [11:0] active_bw_off = 12'h018;
  localparam logic [11:0] id_off        = 12'h01c;
  // Control fields
  localparam int hard_rst_bit  = 0;
  localparam int soft_rst_bit  = 1;
  localparam int fastlock_bit  = 2;
  localparam int oe_bit        = 3;
  // Bandwidth codes: 0 = 0.1 Hz ... 15 = 4 kHz; fast-lock code floor is 100 Hz
  localparam logic [3:0] bw_code_min   = 4'h0;
  localparam logic [3:0] bw_code_max   = 4'hf;
  localparam logic [3:0] fl_code_min   = 4'h9;
  localparam logic [3:0] bw_rst        = 4'h4;
  localparam logic [3:0] fl_rst        = 4'hc;
  localparam logic [31:0] plan_m_rst   = 32'h0000_0064;
  localparam logic [31:0] plan_n_rst   = 32'h0000_000a;
  localparam logic [31:0] id_value     = 32'h0000_5a01; // Arbitrary value
  localparam logic [3:0] load_words    = 4'h8;
  typedef enum logic [2:0] {st_init, st_freerun, st_acquire, st_locked, st_holdover} mode_t;
endpackage

// File: logic/pll_init_reset_mode_control.sv
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module pll_init_reset_mode_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ext_reset_n_pin,
  input  wire logic [3:0]  ref_input_valid,
  input  wire logic        lock_complete,
  input  wire logic [31:0] nv_data,
  output logic      [2:0]  nv_addr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             clk_out_en,
  output logic      [3:0]  active_bw,
  output logic      [1:0]  ref_sel,
  output logic      [2:0]  mode,
  output logic      [31:0] plan_m,
  output logic      [31:0] plan_n,
  output logic             soft_apply
);
  nv_load_if ld ();
  logic [2:0] nv_addr_w;

  nv_loader u_ld (
    .pclk    (pclk),
    .presetn (presetn),
    .ld      (ld.ldr),
    .nv_data (nv_data),
    .nv_addr (nv_addr_w)
  );

  pll_ctrl_pkg::mode_t mode_q;
  logic        init_q;
  logic        start_q;
  logic        hard_req_q;
  logic        pin_q;
  logic        fastlock_q, oe_q;
  logic [3:0]  bw_q, fl_q, act_bw_q;
  logic        auto_q;
  logic [1:0]  man_sel_q, sel_q;
  logic [31:0] pm_q, pn_q, pm_pend_q, pn_pend_q;
  logic        soft_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic        acc, wr, hard_go;

  function automatic logic [1:0] first_valid(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo);
    return (v < lo) ? lo : v;
  endfunction

  assign acc     = psel && penable && !pready_q;
  assign wr      = acc && pwrite && !init_q;
  assign hard_go = !pin_q || hard_req_q;

  // Pin sampled once; the bit self-clears as the reload starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= ext_reset_n_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_req_q <= 1'b0;
    end else if (wr && paddr == pll_ctrl_pkg::ctrl_off && pwdata[pll_ctrl_pkg::hard_rst_bit]) begin
      hard_req_q <= 1'b1;
    end else begin
      hard_req_q <= 1'b0;
    end
  end

  // Init sequencing; power-up and hard reset share one path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q  <= 1'b1;
      start_q <= 1'b1;
    end else if (hard_go) begin
      init_q  <= 1'b1;
      start_q <= 1'b1;
    end else begin
      start_q <= 1'b0;
      if (ld.done && !start_q) begin
        init_q <= 1'b0;
      end
    end
  end
  assign ld.start = start_q;

  // Configuration: loaded from store during init, host writes after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_pend_q  <= pll_ctrl_pkg::plan_m_rst;
      pn_pend_q  <= pll_ctrl_pkg::plan_n_rst;
      bw_q       <= pll_ctrl_pkg::bw_rst;
      fl_q       <= pll_ctrl_pkg::fl_rst;
      fastlock_q <= 1'b0;
      oe_q       <= 1'b1;
      auto_q     <= 1'b1;
      man_sel_q  <= 2'h0;
    end else if (init_q && ld.busy) begin
      case (ld.idx)
        3'h0: pm_pend_q <= ld.word;
        3'h1: pn_pend_q <= ld.word;
        3'h2: bw_q <= ld.word[3:0];
        3'h3: fl_q <= clamp(ld.word[3:0], pll_ctrl_pkg::fl_code_min);
        3'h4: begin
          fastlock_q <= ld.word[pll_ctrl_pkg::fastlock_bit];
          oe_q       <= ld.word[pll_ctrl_pkg::oe_bit];
        end
        3'h5: begin
          auto_q    <= ld.word[2];
          man_sel_q <= ld.word[1:0];
        end
        default: ;
      endcase
    end else if (wr) begin
      case (paddr)
        pll_ctrl_pkg::ctrl_off: begin
          fastlock_q <= pwdata[pll_ctrl_pkg::fastlock_bit];
          oe_q       <= pwdata[pll_ctrl_pkg::oe_bit];
        end
        pll_ctrl_pkg::bw_off: begin
          bw_q <= pwdata[3:0];
          fl_q <= clamp(pwdata[7:4], pll_ctrl_pkg::fl_code_min);
        end
        pll_ctrl_pkg::refsel_off: begin
          auto_q    <= pwdata[2];
          man_sel_q <= pwdata[1:0];
        end
        pll_ctrl_pkg::plan_m_off: pm_pend_q <= pwdata;
        pll_ctrl_pkg::plan_n_off: pn_pend_q <= pwdata;
        default: ;
      endcase
    end
  end

  // Plan goes live at the end of init or on a soft reset only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_q   <= pll_ctrl_pkg::plan_m_rst;
      pn_q   <= pll_ctrl_pkg::plan_n_rst;
      soft_q <= 1'b0;
    end else if (init_q && ld.done && !start_q) begin
      pm_q   <= pm_pend_q;
      pn_q   <= pn_pend_q;
      soft_q <= 1'b0;
    end else if (wr && paddr == pll_ctrl_pkg::ctrl_off && pwdata[pll_ctrl_pkg::soft_rst_bit]) begin
      pm_q   <= pm_pend_q;
      pn_q   <= pn_pend_q;
      soft_q <= 1'b1;
    end else begin
      soft_q <= 1'b0;
    end
  end

  // Reference selection: manual register, or automatic move to lowest valid once the selected input is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 2'h0;
    end else if (!auto_q) begin
      sel_q <= man_sel_q;
    end else if (!ref_input_valid[sel_q] && ref_input_valid != 4'h0) begin
      sel_q <= first_valid(ref_input_valid);
    end
  end

  // Loop mode machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= pll_ctrl_pkg::st_init;
    end else if (init_q) begin
      mode_q <= pll_ctrl_pkg::st_init;
    end else begin
      case (mode_q)
        pll_ctrl_pkg::st_init:     mode_q <= pll_ctrl_pkg::st_freerun;
        pll_ctrl_pkg::st_freerun:
          if (ref_input_valid != 4'h0) mode_q <= pll_ctrl_pkg::st_acquire;
        pll_ctrl_pkg::st_acquire:
          if (!ref_input_valid[sel_q] && ref_input_valid == 4'h0) begin
            mode_q <= pll_ctrl_pkg::st_holdover;
          end else if (lock_complete) begin
            mode_q <= pll_ctrl_pkg::st_locked;
          end
        pll_ctrl_pkg::st_locked:
          if (!ref_input_valid[sel_q] && ref_input_valid == 4'h0) begin
            mode_q <= pll_ctrl_pkg::st_holdover;
          end else if (!lock_complete) begin
            mode_q <= pll_ctrl_pkg::st_acquire;
          end
        pll_ctrl_pkg::st_holdover:
          if (ref_input_valid != 4'h0) mode_q <= pll_ctrl_pkg::st_acquire;
        default: mode_q <= pll_ctrl_pkg::st_freerun;
      endcase
    end
  end

  // Bandwidth in use follows the mode one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_bw_q <= pll_ctrl_pkg::bw_rst;
    end else if (mode_q == pll_ctrl_pkg::st_acquire && fastlock_q) begin
      act_bw_q <= fl_q;
    end else begin
      act_bw_q <= bw_q;
    end
  end

  // Clocks stay off until the load has finished
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_en <= 1'b0;
    end else begin
      clk_out_en <= !init_q && !hard_go && oe_q;
    end
  end

  // APB slave; one wait state, init holds reads/writes off with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && init_q;
      prdata_q  <= 32'h0000_0000;
      if (acc && !pwrite && !init_q) begin
        case (paddr)
          pll_ctrl_pkg::ctrl_off:
            prdata_q <= {28'h0, oe_q, fastlock_q, 2'h0};
          pll_ctrl_pkg::bw_off:        prdata_q <= {24'h0, fl_q, bw_q};
          pll_ctrl_pkg::refsel_off:    prdata_q <= {29'h0, auto_q, man_sel_q};
          pll_ctrl_pkg::plan_m_off:    prdata_q <= pm_pend_q;
          pll_ctrl_pkg::plan_n_off:    prdata_q <= pn_pend_q;
          pll_ctrl_pkg::status_off:
            prdata_q <= {24'h0, sel_q, lock_complete, 2'h0, 3'(mode_q)};
          pll_ctrl_pkg::active_bw_off: prdata_q <= {28'h0, act_bw_q};
          pll_ctrl_pkg::id_off:        prdata_q <= pll_ctrl_pkg::id_value;
          default:                     prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_addr <= 3'h0;
    end else begin
      nv_addr <= nv_addr_w;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign active_bw  = act_bw_q;
  assign ref_sel    = sel_q;
  assign mode       = 3'(mode_q);
  assign plan_m     = pm_q;
  assign plan_n     = pn_q;
  assign soft_apply = soft_q;
endmodule

// File: tb/nv_store_model.sv
`timescale 1ns/1ps
module nv_store_model (
  input  wire logic [2:0]  nv_addr,
  output logic      [31:0] nv_data
);
  logic [31:0] mem [8];
  // Answers at once; the registered address already names the word in use
  assign nv_data = mem[nv_addr];
  initial begin
    mem = '{32'h0000_0123, 32'h0000_0045, 32'h0000_0002, 32'h0000_000d,
            32'h0000_000c, 32'h0000_0004, 32'h0000_0000, 32'h0000_0000};
  end
endmodule

// File: tb/pll_ctrl_properties.sv
`timescale 1ns/1ps
module pll_ctrl_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ext_reset_n_pin,
  input wire logic [3:0] ref_input_valid,
  input wire logic       lock_complete,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       clk_out_en,
  input wire logic [2:0] mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_init_end;
    mode == 3'h0 ##1 mode != 3'h0;
  endsequence
  sequence s_early_req;
    psel && penable && !pready && mode == 3'h0;
  endsequence
  AST_INIT_NO_CLK: assert property (mode == 3'h0 && $past(mode) == 3'h0 |-> !clk_out_en)
    else $error("clocks on during init");
  AST_INIT_REFUSE: assert property (s_early_req |=> pready && pslverr)
    else $error("access not refused in init");
  AST_MODE_LEGAL: assert property ((mode == 3'h1 || mode == 3'h4)
    |=> mode == 3'h0 || mode == 3'h2 || mode == $past(mode))
    else $error("illegal mode step");
  AST_FREERUN: assert property (s_init_end |-> mode == 3'h1)
    else $error("init not followed by freerun");
  AST_PIN_RESET: assert property (!ext_reset_n_pin |-> ##[1:3] mode == 3'h0)
    else $error("pin reset ignored");
  AST_ACQUIRE: assert property (mode == 3'h1 && ref_input_valid != 4'h0 |-> ##[1:3] mode == 3'h2)
    else $error("no acquisition from freerun");
  AST_LOCK: assert property (mode == 3'h2 && lock_complete && ref_input_valid != 4'h0
    |-> ##[1:3] mode == 3'h3)
    else $error("lock not entered");
  AST_UNLOCK: assert property (mode == 3'h3 && !lock_complete |-> ##[1:3] mode != 3'h3)
    else $error("locked kept without lock");
  AST_HOLD: assert property (mode == 3'h2 && ref_input_valid == 4'h0 && !lock_complete
    |-> ##[1:3] mode == 3'h4)
    else $error("holdover not entered");
  AST_HOLD_EXIT: assert property (mode == 3'h4 && ref_input_valid != 4'h0 |-> ##[1:3] mode == 3'h2)
    else $error("holdover not left");
endmodule
bind pll_init_reset_mode_control pll_ctrl_properties i_props (.pclk, .presetn, .ext_reset_n_pin,
  .ref_input_valid, .lock_complete, .psel, .penable, .pready, .pslverr, .clk_out_en, .mode);

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, ext_reset_n_pin, lock_complete, psel, penable, pwrite;
  logic [3:0]  ref_input_valid, active_bw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, plan_m, plan_n, nv_data, rd;
  logic [2:0]  nv_addr, mode;
  logic [1:0]  ref_sel;
  logic        pready, pslverr, clk_out_en, soft_apply, er;
  int          err_total = 0;
  int          compares = 0;
  int          soft_cnt = 0;
  pll_init_reset_mode_control i_dut (.pclk, .presetn, .ext_reset_n_pin, .ref_input_valid,
    .lock_complete, .nv_data, .nv_addr, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clk_out_en, .active_bw, .ref_sel, .mode, .plan_m, .plan_n, .soft_apply);
  nv_store_model i_store (.nv_addr, .nv_data);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (soft_apply === 1'b1) soft_cnt++;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // Waits on pready alone; only the watchdog ends a hung transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 40 && mode !== m; i++) @(posedge pclk);
    chk("mode", {29'h0, mode}, {29'h0, m});
  endtask
  task automatic test_init();
    apb(1'b0, pll_ctrl_pkg::ctrl_off, 32'h0);
    chk("early err", {31'h0, er}, 32'h1);
    chk("early rd", rd, 32'h0);
    chk("clk early", {31'h0, clk_out_en}, 32'h0);
    wait_mode(3'h1);
    chk("plan m", plan_m, 32'h0000_0123);
    chk("plan n", plan_n, 32'h0000_0045);
    @(posedge pclk);
    chk("clk on", {31'h0, clk_out_en}, 32'h1);
  endtask
  task automatic test_soft();
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h0);
    apb(1'b1, pll_ctrl_pkg::bw_off, 32'h0000_003f);
    apb(1'b1, pll_ctrl_pkg::refsel_off, 32'h0000_0002);
    apb(1'b1, pll_ctrl_pkg::plan_m_off, 32'h0000_0077);
    chk("pending", plan_m, 32'h0000_0123);
    apb(1'b1, pll_ctrl_pkg::ctrl_off, 32'h0000_000e);
    repeat (3) @(posedge pclk);
    chk("soft pulse", soft_cnt, 32'h1);
    chk("soft plan", plan_m, 32'h0000_0077);
    chk("soft mode", {29'h0, mode}, 32'h1);
    chk("manual sel", {30'h0, ref_sel}, 32'h2);
  endtask
  task automatic test_modes();
    ref_input_valid <= 4'h1;
    wait_mode(3'h2);
    // Bandwidth in use trails the mode by a cycle
    @(posedge pclk);
    chk("fast bw", {28'h0, active_bw}, 32'h9);
    lock_complete <= 1'b1;
    wait_mode(3'h3);
    @(posedge pclk);
    chk("norm bw", {28'h0, active_bw}, 32'hf);
    apb(1'b0, pll_ctrl_pkg::status_off, 32'h0);
    chk("status", {29'h0, rd[2:0]}, 32'h3);
    lock_complete <= 1'b0;
    wait_mode(3'h2);
    ref_input_valid <= 4'h0;
    wait_mode(3'h4);
    ref_input_valid <= 4'h2;
    wait_mode(3'h2);
    ref_input_valid <= 4'h0;
    wait_mode(3'h4);
    apb(1'b1, pll_ctrl_pkg::refsel_off, 32'h0000_0004);
    ref_input_valid <= 4'ha;
    wait_mode(3'h2);
    chk("auto sel", {30'h0, ref_sel}, 32'h1);
    ref_input_valid <= 4'h0;
    wait_mode(3'h4);
  endtask
  task automatic test_hard();
    apb(1'b1, pll_ctrl_pkg::ctrl_off, 32'h0000_0001);
    wait_mode(3'h0);
    wait_mode(3'h1);
    chk("reg reload", plan_m, 32'h0000_0123);
    apb(1'b1, pll_ctrl_pkg::plan_m_off, 32'h0000_0055);
    apb(1'b1, pll_ctrl_pkg::ctrl_off, 32'h0000_000e);
    ext_reset_n_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_reset_n_pin <= 1'b1;
    @(posedge pclk);
    chk("pin mode", {29'h0, mode}, 32'h0);
    chk("pin clk", {31'h0, clk_out_en}, 32'h0);
    wait_mode(3'h1);
    chk("pin reload", plan_m, 32'h0000_0123);
  endtask
  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    ext_reset_n_pin = 1'b1;
    lock_complete = 1'b0;
    ref_input_valid = 4'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    test_init();
    test_soft();
    test_modes();
    test_hard();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    stop_test();
  end
endmodule
